// [hw/ctc_pkg.sv]
package ctc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int CTC_ADDR_W = 8;
	localparam int CTC_DATA_W = 8;
	localparam logic [7:0] CTC_CFG_OFFSET = 8'h08;
	localparam logic [7:0] CTC_CFG_RESET = 8'h14;

	// ----------------------------------------------------------------
	// Field layout of the configuration register
	// ----------------------------------------------------------------
	localparam int CTC_HOT_SEL_LSB = 6;
	localparam int CTC_HOT_SEL_W = 2;
	localparam int CTC_MASK_BIT = 5;
	localparam int CTC_SPARE_BIT = 4;
	localparam int CTC_CUR_SEL_LSB = 0;
	localparam int CTC_CUR_SEL_W = 4;

	// ----------------------------------------------------------------
	// Decode constants
	// ----------------------------------------------------------------
	// Hot limits in tenths of a percent of the thermistor ratio.
	localparam logic [9:0] CTC_HOT_RATIO_00 = 10'h118;
	localparam logic [9:0] CTC_HOT_RATIO_01 = 10'h11d;
	localparam logic [9:0] CTC_HOT_RATIO_10 = 10'h122;
	localparam logic [9:0] CTC_HOT_RATIO_11 = 10'h127;
	// Charge current step in milliamps and ceiling as a select code.
	localparam logic [10:0] CTC_CUR_STEP_MA = 11'h064;
	localparam logic [3:0] CTC_CUR_MAX_CODE = 4'hb;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] hot_ratio_threshold_sel;
		logic input_limit_event_mask;
		logic spare;
		logic [3:0] charge_current_sel;
	} ctc_cfg_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} ctc_req_s;

	typedef enum logic [0:0] {
		CTC_INT_IDLE = 1'b0,
		CTC_INT_PEND = 1'b1
	} ctc_int_e;

endpackage

// [hw/ctc_charger_config.sv]
`timescale 1ns/1ps
// How it works
// - With the event mask at 0, each change of the input power-limit state raises the interrupt.
// - With the event mask at 1, changes of the input power-limit state raise no interrupt.
// - The 2-bit hot select field sets the thermistor ratio limit that flags a hot battery.
// - Hot select codes 00, 01, 10, 11 give limits of 28%, 28.5%, 29% and 29.5%.
// - An interrupt pulls the open-drain line low and sets a status bit that is its inverse.
module ctc_charger_config
(
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_arst_n,
	// Register port from the serial control interface
	input wire ctc_pkg::ctc_req_s i_req,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// Charger status input and interrupt clear
	input wire logic i_input_power_limit_state,
	input wire logic i_int_status_clr,
	// Open-drain interrupt line
	output logic o_int_out,
	output logic o_int_oe,
	output logic o_int_status,
	// Decoded settings for the analog charger loop
	output logic [1:0] o_hot_ratio_threshold_sel,
	output logic [9:0] o_hot_ratio_limit,
	output logic [10:0] o_charge_current_ma
);
	import ctc_pkg::*;

	// ----------------------------------------------------------------
	// Decode functions
	// ----------------------------------------------------------------
	function automatic logic [9:0] hot_limit(input logic [1:0] sel);
		logic [9:0] lim;
		lim = CTC_HOT_RATIO_00;
		case (sel)
			2'h0: lim = CTC_HOT_RATIO_00;
			2'h1: lim = CTC_HOT_RATIO_01;
			2'h2: lim = CTC_HOT_RATIO_10;
			2'h3: lim = CTC_HOT_RATIO_11;
			default: lim = CTC_HOT_RATIO_00;
		endcase
		return lim;
	endfunction

	function automatic logic [10:0] cur_ma(input logic [3:0] code);
		logic [3:0] eff;
		logic [14:0] prod;
		// Codes above the ceiling all map to the top current.
		eff = (code > CTC_CUR_MAX_CODE) ? CTC_CUR_MAX_CODE : code;
		prod = 15'({11'h000, eff} + 15'h0001) * 15'(CTC_CUR_STEP_MA);
		return prod[10:0];
	endfunction

	// ----------------------------------------------------------------
	// Configuration register
	// ----------------------------------------------------------------
	ctc_cfg_s cfg_ff;
	logic cfg_hit;

	assign cfg_hit = (i_req.addr == CTC_CFG_OFFSET);

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			cfg_ff <= ctc_cfg_s'(CTC_CFG_RESET);
		end
		else if (i_req.wr && cfg_hit)
		begin
			cfg_ff <= ctc_cfg_s'(i_req.wdata);
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Unmapped addresses read as zero so the serial side always has an answer.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_reg_rdata <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_req.rd;
			if (i_req.rd)
			begin
				o_reg_rdata <= cfg_hit ? 8'(cfg_ff) : 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Power-limit change detection
	// ----------------------------------------------------------------
	// Seeded from the live input on the first clocked cycle, so the state
	// present at power-up is not mistaken for a change.
	logic limit_prev_ff;
	logic seeded_ff;
	logic limit_event;

	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			limit_prev_ff <= 1'b0;
			seeded_ff <= 1'b0;
		end
		else
		begin
			limit_prev_ff <= i_input_power_limit_state;
			seeded_ff <= 1'b1;
		end
	end

	assign limit_event = seeded_ff && (limit_prev_ff != i_input_power_limit_state)
		&& !cfg_ff.input_limit_event_mask;

	// ----------------------------------------------------------------
	// Interrupt status and line
	// ----------------------------------------------------------------
	ctc_int_e int_state_ff;
	ctc_int_e nxt_int_state;

	always_comb
	begin
		nxt_int_state = int_state_ff;
		case (int_state_ff)
			CTC_INT_IDLE:
			begin
				if (limit_event)
				begin
					nxt_int_state = CTC_INT_PEND;
				end
			end
			CTC_INT_PEND:
			begin
				// A new event in the clearing cycle keeps the line asserted.
				if (i_int_status_clr && !limit_event)
				begin
					nxt_int_state = CTC_INT_IDLE;
				end
			end
			default: nxt_int_state = CTC_INT_IDLE;
		endcase
	end

	// State register of the interrupt.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			int_state_ff <= CTC_INT_IDLE;
		end
		else
		begin
			int_state_ff <= nxt_int_state;
		end
	end

	// Enable of the open-drain driver, high while the line is pulled low.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_int_oe <= 1'b0;
		end
		else
		begin
			o_int_oe <= (nxt_int_state == CTC_INT_PEND);
		end
	end

	// Status bit, the inverse of the line level seen by the host.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_int_status <= 1'b0;
		end
		else
		begin
			o_int_status <= (nxt_int_state == CTC_INT_PEND);
		end
	end

	// The open-drain data stays at 0 so the pin can only pull low, never drive high.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_int_out <= 1'b0;
		end
		else
		begin
			o_int_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Decoded settings
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_hot_ratio_threshold_sel <= 2'h0;
			o_hot_ratio_limit <= CTC_HOT_RATIO_00;
			o_charge_current_ma <= 11'h000;
		end
		else
		begin
			o_hot_ratio_threshold_sel <= cfg_ff.hot_ratio_threshold_sel;
			o_hot_ratio_limit <= hot_limit(cfg_ff.hot_ratio_threshold_sel);
			o_charge_current_ma <= cur_ma(cfg_ff.charge_current_sel);
		end
	end

endmodule // ctc_charger_config

// [verification/ctc_charger_config_props.sv]
`timescale 1ns/1ps
module ctc_charger_config_props
(
	// Watched ports
	input logic i_clk_sys,
	input logic i_arst_n,
	input ctc_pkg::ctc_req_s i_req,
	input logic i_input_power_limit_state,
	input logic i_int_status_clr,
	input logic o_reg_rvalid,
	input logic [7:0] o_reg_rdata,
	input logic o_int_out,
	input logic o_int_oe,
	input logic o_int_status,
	input logic [1:0] o_hot_ratio_threshold_sel,
	input logic [9:0] o_hot_ratio_limit,
	input logic [10:0] o_charge_current_ma
);
	import ctc_pkg::*;
	logic [7:0] cfg_ff;
	// Shadow of the register, so the decode is judged only against writes seen at the port.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
		if (!i_arst_n)
			cfg_ff <= CTC_CFG_RESET;
		else if (i_req.wr && i_req.addr == CTC_CFG_OFFSET)
			cfg_ff <= i_req.wdata;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_arst_n);
	// The first edge after reset only seeds history, so both sequences wait one edge.
	sequence s_live; $past(i_arst_n); endsequence
	sequence s_event; $past(i_arst_n) && $changed(i_input_power_limit_state); endsequence
	a_event_raises_int: assert property (s_event ##0 !cfg_ff[5] |=> o_int_oe)
		else $error("missed");
	a_masked_stays_idle: assert property (s_event ##0 cfg_ff[5] && !o_int_oe |=> !o_int_oe)
		else $error("masked");
	a_hot_sel_copy: assert property (s_live |-> o_hot_ratio_threshold_sel == $past(cfg_ff[7:6]))
		else $error("sel");
	a_hot_limit_map: assert property (s_live |-> o_hot_ratio_limit == 10'h118 + 10'h005 * $past(cfg_ff[7:6]))
		else $error("limit");
	a_current_map: assert property (s_live |-> o_charge_current_ma ==
		($past(cfg_ff[3:0]) > 4'hb ? 11'h4b0 : 11'h064 * ($past(cfg_ff[3:0]) + 11'h001)))
		else $error("current");
	a_status_is_line: assert property (o_int_status == o_int_oe)
		else $error("status");
	sequence s_clear; o_int_oe && i_int_status_clr; endsequence
	sequence s_read; i_req.rd && i_req.addr == CTC_CFG_OFFSET; endsequence
	a_line_pulls_low: assert property (o_int_oe |-> !o_int_out)
		else $error("line data not low");
	a_pending_holds: assert property (o_int_oe && !i_int_status_clr |=> o_int_oe)
		else $error("pending dropped");
	a_clear_releases: assert property (s_clear ##0 !$changed(i_input_power_limit_state) |=> !o_int_oe)
		else $error("clear ignored");
	a_read_valid: assert property (s_live |-> o_reg_rvalid == $past(i_req.rd))
		else $error("read valid");
	a_read_data: assert property (s_read |=> o_reg_rdata == $past(cfg_ff))
		else $error("read data");
endmodule // ctc_charger_config_props
bind ctc_charger_config ctc_charger_config_props props_u
(
	.i_clk_sys(i_clk_sys),
	.i_arst_n(i_arst_n),
	.i_req(i_req),
	.i_input_power_limit_state(i_input_power_limit_state),
	.i_int_status_clr(i_int_status_clr),
	.o_reg_rvalid(o_reg_rvalid),
	.o_reg_rdata(o_reg_rdata),
	.o_int_out(o_int_out),
	.o_int_oe(o_int_oe),
	.o_int_status(o_int_status),
	.o_hot_ratio_threshold_sel(o_hot_ratio_threshold_sel),
	.o_hot_ratio_limit(o_hot_ratio_limit),
	.o_charge_current_ma(o_charge_current_ma)
);

// [verification/ctc_host_model.sv]
`timescale 1ns/1ps
module ctc_host_model
(
	// Clock, reset, interrupt line and service delay
	input logic i_clk_sys,
	input logic i_arst_n,
	input logic i_int_n,
	input logic [3:0] i_delay,
	// Clear strobe, a write of 0 to the status bit
	output logic o_clr
);
	logic [3:0] wait_ff;
	// Counts the cycles the line has been low, saturating so a slow host never wraps.
	always_ff @(posedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			wait_ff <= 4'h0;
		else if (i_int_n)
			wait_ff <= 4'h0;
		else if (wait_ff != 4'hf)
			wait_ff <= wait_ff + 4'h1;
	end
	// The clear is launched on the falling edge like the rest of the stimulus, and it
	// is repeated every other cycle while the line stays low after a lost clear.
	always_ff @(negedge i_clk_sys or negedge i_arst_n)
	begin
		if (!i_arst_n)
			o_clr <= 1'b0;
		else
			o_clr <= !i_int_n && !o_clr && (wait_ff >= i_delay);
	end
endmodule // ctc_host_model

// [verification/charger_thermal_current_config_tb.sv]
`timescale 1ns/1ps
module charger_thermal_current_config_tb;
	import ctc_pkg::*;
	logic i_clk_sys, i_arst_n, i_input_power_limit_state, i_int_status_clr;
	logic o_reg_rvalid, o_int_out, o_int_oe, o_int_status;
	logic [3:0] host_delay;
	ctc_req_s i_req;
	logic [7:0] o_reg_rdata, d;
	logic [1:0] o_hot_ratio_threshold_sel;
	logic [9:0] o_hot_ratio_limit;
	logic [10:0] o_charge_current_ma;
	int err_total, n_checks, cyc;
	ctc_charger_config dut_u
	(
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_req(i_req),
		.o_reg_rdata(o_reg_rdata),
		.o_reg_rvalid(o_reg_rvalid),
		.i_input_power_limit_state(i_input_power_limit_state),
		.i_int_status_clr(i_int_status_clr),
		.o_int_out(o_int_out),
		.o_int_oe(o_int_oe),
		.o_int_status(o_int_status),
		.o_hot_ratio_threshold_sel(o_hot_ratio_threshold_sel),
		.o_hot_ratio_limit(o_hot_ratio_limit),
		.o_charge_current_ma(o_charge_current_ma)
	);
	ctc_host_model host_u
	(
		.i_clk_sys(i_clk_sys),
		.i_arst_n(i_arst_n),
		.i_int_n(!o_int_oe),
		.i_delay(host_delay),
		.o_clr(i_int_status_clr)
	);
	initial
	begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = !i_clk_sys;
	end
	always @(posedge i_clk_sys)
		if (++cyc == 4000)
		begin
			err_total++;
			tally_and_finish();
		end
	task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("ERROR %s expected %h seen %h", n, e, g);
			err_total++;
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(negedge i_clk_sys) i_req = '{w, !w, a, v};
		@(negedge i_clk_sys) i_req = '0;
		chk("rvalid", {10'h0, !w}, {10'h0, o_reg_rvalid});
	endtask
	function automatic logic [10:0] exp_ma(input logic [3:0] c);
		return (c > 4'hb) ? 11'h4b0 : 11'h064 * {7'h0, c + 4'h1};
	endfunction
	task automatic tally_and_finish();
		if (err_total == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		i_req = '0;
		host_delay = 4'h0;
		{i_arst_n, i_input_power_limit_state} = '0;
		void'($urandom(18005));
		repeat (3) @(negedge i_clk_sys);
		i_arst_n = 1'b1;
		bus(1'b0, CTC_CFG_OFFSET, 8'h00);
		chk("reset", {3'h0, CTC_CFG_RESET}, {3'h0, o_reg_rdata});
		chk("current_rst", exp_ma(CTC_CFG_RESET[3:0]), o_charge_current_ma);
		chk("limit_rst", {1'b0, CTC_HOT_RATIO_00}, {1'b0, o_hot_ratio_limit});
		chk("status_rst", 11'h000, {10'h0, o_int_status});
		for (int i = 0; i < 60; i++)
		begin
			d = (i < 16) ? {i[1:0], i[0], 1'b0, i[3:0]} : 8'($urandom);
			bus(1'b1, CTC_CFG_OFFSET, d);
			bus(1'b1, 8'($urandom) | 8'h10, ~d);
			bus(1'b0, CTC_CFG_OFFSET, 8'h00);
			chk("readback", {3'h0, d}, {3'h0, o_reg_rdata});
			chk("limit", 11'h118 + 11'h005 * {9'h0, d[7:6]}, {1'b0, o_hot_ratio_limit});
			chk("current", exp_ma(d[3:0]), o_charge_current_ma);
			chk("sel", {9'h0, d[7:6]}, {9'h0, o_hot_ratio_threshold_sel});
			repeat (20) if (o_int_oe) @(negedge i_clk_sys);
			chk("released", 11'h000, {10'h0, o_int_oe});
			host_delay = (i < 4) ? 4'h0 : 4'($urandom);
			i_input_power_limit_state = !i_input_power_limit_state;
			@(negedge i_clk_sys);
			chk("event", {10'h0, !d[5]}, {10'h0, o_int_status});
			chk("line", {10'h0, !d[5]}, {10'h0, o_int_oe});
			chk("line_data", 11'h000, {10'h0, o_int_out});
			if (host_delay == 4'h0 && !d[5])
			begin
				// A second change lands on the edge that carries the host's clear, so the set must win.
				i_input_power_limit_state = !i_input_power_limit_state;
				@(negedge i_clk_sys);
				chk("set_wins", 11'h001, {10'h0, o_int_status});
			end
		end
		tally_and_finish();
	end
endmodule // charger_thermal_current_config_tb
